// file: include/icf_consts.svh
`ifndef ICF_CONSTS_SVH
`define ICF_CONSTS_SVH

// Register byte offsets.
`define ICF_OFF_CTRL 6'h00
`define ICF_OFF_STATUS 6'h04
`define ICF_OFF_FLAGS 6'h08
`define ICF_OFF_ENABLE 6'h0C

// Control register fields.
`define ICF_CTRL_EN 0
`define ICF_CTRL_MST 1
`define ICF_CTRL_GCALL 2
`define ICF_CTRL_INTERACTIVE_RECEIVE 3
`define ICF_CTRL_INTERACTIVE_RECEIVE_NACK 4
`define ICF_CTRL_SCL_OUT 6
`define ICF_CTRL_SDA_OUT 7
`define ICF_CTRL_SCL_PIN 8
`define ICF_CTRL_SDA_PIN 9
`define ICF_CTRL_SW 10
`define ICF_CTRL_RW 11
`define ICF_CTRL_NOSTRETCH 12
`define ICF_CTRL_SINGLE 13
`define ICF_CTRL_HS 15
`define ICF_CTRL_WMASK 16'hB4DF

// Event flag positions.
`define ICF_FL_DONE 0
`define ICF_FL_INTERACTIVE_RECEIVE 1
`define ICF_FL_GCALL 2
`define ICF_FL_AMATCH 3
`define ICF_FL_RXTH 4
`define ICF_FL_TXTH 5
`define ICF_FL_STOP 6
`define ICF_FL_AACK 7
`define ICF_FL_ARB 8
`define ICF_FL_TMO 9
`define ICF_FL_ANACK 10
`define ICF_FL_DNACK 11
`define ICF_FL_NREADY 12
`define ICF_FL_MSTART 13
`define ICF_FL_MSTOP 14
`define ICF_FL_TXLOCK 15
`define ICF_FL_RDMATCH 22
`define ICF_FL_WRMATCH 23
`define ICF_FL_W1C 24'hC0FFCF
`define ICF_EN_WMASK 24'hC0FFFF

// Reset values.
`define ICF_FL_RESET 24'h000030
`define ICF_ST_FIFO_RESET 4'h5
`define ICF_SYNC_RESET 3'h7

`endif

// file: include/icf_pkg.sv
package icf_pkg;

   // Whole state of the control and flag block.
   typedef struct packed {
      logic wreq;
      logic [31:0] rdata;
      logic [15:0] ctrl;
      logic rw;
      logic [23:0] flags;
      logic [23:0] enables;
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic busy;
      logic mact;
      logic [3:0] fifo_st;
      logic irq;
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } icf_state_t;

endpackage

// file: logic/icf_control_flags.sv
`timescale 1ns/100ps
`include "icf_consts.svh"

// What this block does
// - Bit 0 enables; bit 1 selects master role.
// - Bit 2 accepts or ignores general call.
// - Bit 3 raises event per received byte.
// - Bit 4 picks ACK or NACK reply.
// - Bit 10 hands both lines to software.
// - Bits 7/6 drive lines; 9/8 read pins.
// - Bit 11 holds received read/write bit.
// - Bit 12 forbids slave clock stretching.
// - Status bit 5 marks own master transaction.
// - Status bit 0 marks any bus transaction.
// - Status bits 4..1 report FIFO full/empty states.
// - Slave address and general call match flags.
// - Lock flag flushes and blocks transmit FIFO.
// - Flags 14/13 mark misplaced STOP/START.
// - Flag 12 marks match with FIFO unready.
// - Flag 9 marks own clock hold timeout.
// - Flags 7/8 mark address ACK, arbitration lost.
// - Flag 5 tracks transmit count at threshold.
// - Flag 4 tracks receive count at threshold.
// - Flags 0/6/1 set; write one clears.
// - Enable register mirrors flags, resets zero.
module icf_control_flags (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Avalon-MM register slave.
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Two-wire bus pins.
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Protocol engine requests and events.
   input wire logic hw_scl_low,
   input wire logic hw_sda_low,
   input wire logic ev_addr_match,
   input wire logic ev_gen_call,
   input wire logic ev_rw_bit,
   input wire logic ev_fifo_not_ready,
   input wire logic ev_data_nack,
   input wire logic ev_addr_nack,
   input wire logic ev_hold_timeout,
   input wire logic ev_arb_lost,
   input wire logic ev_addr_ack,
   input wire logic ev_done,
   input wire logic ev_rx_byte,
   input wire logic ev_tx_lock,
   input wire logic ev_misplaced_start,
   input wire logic ev_misplaced_stop,
   // FIFO state.
   input wire logic tx_full,
   input wire logic tx_empty,
   input wire logic rx_full,
   input wire logic rx_empty,
   input wire logic [3:0] tx_count,
   input wire logic [3:0] rx_count,
   input wire logic [3:0] tx_thresh,
   input wire logic [3:0] rx_thresh,
   // Configuration to the engine.
   output logic periph_enable,
   output logic master_mode,
   output logic general_call_accept,
   output logic interactive_receive,
   output logic interactive_nack,
   output logic stretch_disable,
   output logic single_master_drive,
   output logic high_speed_enable,
   output logic tx_lock_flush,
   // Interrupt request.
   output logic irq
);

   icf_pkg::icf_state_t st_reg;
   icf_pkg::icf_state_t st_next;

   logic wr_ok;
   logic rd_ok;
   logic [31:0] be_bits;
   logic [15:0] ctrl_view;
   logic [31:0] rd_word;
   logic [23:0] fl_set;
   logic [23:0] fl_clr;
   logic scl_high;
   logic start_det;
   logic stop_det;
   logic en;
   logic mst;

   function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] off);
      reg_hit = (addr[5:2] == off[5:2]);
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   always_comb begin
      st_next = st_reg;
      en = st_reg.ctrl[`ICF_CTRL_EN];
      mst = st_reg.ctrl[`ICF_CTRL_MST];
      // A transfer completes on the cycle that waitrequest is low.
      wr_ok = avs_write && !st_reg.wreq;
      rd_ok = avs_read && st_reg.wreq;
      be_bits = lane_mask(avs_byteenable);
      st_next.wreq = !((avs_read || avs_write) && st_reg.wreq);

      // Pins pass two flip-flops; the third stage only serves edge detection.
      st_next.scl_sync = {st_reg.scl_sync[1:0], scl_i};
      st_next.sda_sync = {st_reg.sda_sync[1:0], sda_i};
      scl_high = st_reg.scl_sync[1] && st_reg.scl_sync[2];
      start_det = scl_high && st_reg.sda_sync[2] && !st_reg.sda_sync[1];
      stop_det = scl_high && !st_reg.sda_sync[2] && st_reg.sda_sync[1];

      ctrl_view = st_reg.ctrl;
      ctrl_view[`ICF_CTRL_SCL_PIN] = st_reg.scl_sync[1];
      ctrl_view[`ICF_CTRL_SDA_PIN] = st_reg.sda_sync[1];
      ctrl_view[`ICF_CTRL_RW] = st_reg.rw;

      rd_word = 32'h0000_0000;
      if (reg_hit(avs_address, `ICF_OFF_CTRL)) begin
         rd_word = {16'h0000, ctrl_view};
      end else if (reg_hit(avs_address, `ICF_OFF_STATUS)) begin
         rd_word = {26'h000_0000, st_reg.mact, st_reg.fifo_st, st_reg.busy};
      end else if (reg_hit(avs_address, `ICF_OFF_FLAGS)) begin
         rd_word = {8'h00, st_reg.flags};
      end else if (reg_hit(avs_address, `ICF_OFF_ENABLE)) begin
         rd_word = {8'h00, st_reg.enables};
      end
      if (rd_ok) begin
         st_next.rdata = rd_word;
      end

      // Control write; read-only bits keep their stored zero.
      if (wr_ok && reg_hit(avs_address, `ICF_OFF_CTRL)) begin
         st_next.ctrl = (st_reg.ctrl & ~(be_bits[15:0] & `ICF_CTRL_WMASK))
            | (avs_writedata[15:0] & be_bits[15:0] & `ICF_CTRL_WMASK);
      end
      if (wr_ok && reg_hit(avs_address, `ICF_OFF_ENABLE)) begin
         st_next.enables = (st_reg.enables & ~(be_bits[23:0] & `ICF_EN_WMASK))
            | (avs_writedata[23:0] & be_bits[23:0] & `ICF_EN_WMASK);
      end

      // Received read/write bit is caught with the match flag.
      if (en && !mst && (ev_addr_match || (ev_gen_call && st_reg.ctrl[`ICF_CTRL_GCALL]))) begin
         st_next.rw = ev_rw_bit;
      end

      // Bus activity seen from the pins in either role.
      if (start_det) begin
         st_next.busy = 1'b1;
      end else if (stop_det) begin
         st_next.busy = 1'b0;
      end
      // Stays set through slave clock stretching since only STOP or a cleared enable bit ends it.
      if (start_det && en && mst) begin
         st_next.mact = 1'b1;
      end else if (stop_det || !en) begin
         st_next.mact = 1'b0;
      end
      st_next.fifo_st = {tx_full, tx_empty, rx_full, rx_empty};

      fl_set = 24'h00_0000;
      if (en) begin
         fl_set[`ICF_FL_DONE] = ev_done;
         fl_set[`ICF_FL_STOP] = stop_det;
         // Mode bit is meant to change only while idle, so no sync is applied.
         fl_set[`ICF_FL_INTERACTIVE_RECEIVE] = ev_rx_byte && st_reg.ctrl[`ICF_CTRL_INTERACTIVE_RECEIVE];
         fl_set[`ICF_FL_TMO] = ev_hold_timeout;
         fl_set[`ICF_FL_TXLOCK] = ev_tx_lock;
         fl_set[`ICF_FL_MSTOP] = ev_misplaced_stop;
         fl_set[`ICF_FL_MSTART] = ev_misplaced_start;
         if (!mst) begin
            fl_set[`ICF_FL_AMATCH] = ev_addr_match;
            fl_set[`ICF_FL_WRMATCH] = ev_addr_match && !ev_rw_bit;
            fl_set[`ICF_FL_RDMATCH] = ev_addr_match && ev_rw_bit;
            fl_set[`ICF_FL_GCALL] = ev_gen_call && st_reg.ctrl[`ICF_CTRL_GCALL];
            fl_set[`ICF_FL_NREADY] = ev_addr_match && ev_fifo_not_ready;
         end else begin
            fl_set[`ICF_FL_DNACK] = ev_data_nack;
            fl_set[`ICF_FL_ANACK] = ev_addr_nack;
            fl_set[`ICF_FL_AACK] = ev_addr_ack;
            fl_set[`ICF_FL_ARB] = ev_arb_lost;
         end
      end
      fl_clr = 24'h00_0000;
      if (wr_ok && reg_hit(avs_address, `ICF_OFF_FLAGS)) begin
         fl_clr = avs_writedata[23:0] & be_bits[23:0] & `ICF_FL_W1C;
      end
      // A new event beats a clear in the same cycle.
      st_next.flags = (st_reg.flags & ~fl_clr) | fl_set;
      st_next.flags[`ICF_FL_TXTH] = (tx_count <= tx_thresh);
      st_next.flags[`ICF_FL_RXTH] = (rx_count >= rx_thresh);

      st_next.irq = |(st_reg.flags & st_reg.enables);

      // Open-drain lines: output enable pulls low, except push-pull SCL.
      st_next.scl_o = 1'b0;
      st_next.sda_o = 1'b0;
      if (st_reg.ctrl[`ICF_CTRL_SW]) begin
         st_next.scl_oe = !st_reg.ctrl[`ICF_CTRL_SCL_OUT];
         st_next.sda_oe = !st_reg.ctrl[`ICF_CTRL_SDA_OUT];
      end else if (en) begin
         st_next.sda_oe = hw_sda_low;
         // Driving SCL high is safe only when no one else holds it low.
         if (st_reg.ctrl[`ICF_CTRL_SINGLE]) begin
            st_next.scl_oe = 1'b1;
            st_next.scl_o = !hw_scl_low;
         end else begin
            st_next.scl_oe = hw_scl_low;
         end
      end else begin
         st_next.scl_oe = 1'b0;
         st_next.sda_oe = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
         st_reg.wreq <= 1'b1;
         st_reg.flags <= `ICF_FL_RESET;
         st_reg.fifo_st <= `ICF_ST_FIFO_RESET;
         st_reg.scl_sync <= `ICF_SYNC_RESET;
         st_reg.sda_sync <= `ICF_SYNC_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign avs_readdata = st_reg.rdata;
   assign avs_waitrequest = st_reg.wreq;
   assign scl_o = st_reg.scl_o;
   assign scl_oe = st_reg.scl_oe;
   assign sda_o = st_reg.sda_o;
   assign sda_oe = st_reg.sda_oe;
   assign periph_enable = st_reg.ctrl[`ICF_CTRL_EN];
   assign master_mode = st_reg.ctrl[`ICF_CTRL_MST];
   assign general_call_accept = st_reg.ctrl[`ICF_CTRL_GCALL];
   assign interactive_receive = st_reg.ctrl[`ICF_CTRL_INTERACTIVE_RECEIVE];
   assign interactive_nack = st_reg.ctrl[`ICF_CTRL_INTERACTIVE_RECEIVE_NACK];
   assign stretch_disable = st_reg.ctrl[`ICF_CTRL_NOSTRETCH];
   assign single_master_drive = st_reg.ctrl[`ICF_CTRL_SINGLE];
   assign high_speed_enable = st_reg.ctrl[`ICF_CTRL_HS];
   assign tx_lock_flush = st_reg.flags[`ICF_FL_TXLOCK];
   assign irq = st_reg.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   bus_one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest did not drop after one cycle");

   gcall_gate_a: assert property ($rose(st_reg.flags[`ICF_FL_GCALL]) |-> $past(st_reg.ctrl[`ICF_CTRL_GCALL]))
      else $error("general call flag set while ignored");

   interactive_receive_gate_a: assert property ($rose(st_reg.flags[`ICF_FL_INTERACTIVE_RECEIVE]) |-> $past(st_reg.ctrl[`ICF_CTRL_INTERACTIVE_RECEIVE]))
      else $error("interactive receive flag set while disabled");

   sw_pin_a: assert property (st_reg.ctrl[`ICF_CTRL_SW] && !st_reg.ctrl[`ICF_CTRL_SCL_OUT]
      |=> scl_oe && !scl_o)
      else $error("software clock low not driven");

   rw_capture_a: assert property (ev_addr_match && periph_enable && !master_mode
      |=> st_reg.rw == $past(ev_rw_bit))
      else $error("read/write bit not captured");

   bus_busy_a: assert property (start_det |=> st_reg.busy)
      else $error("start did not mark bus busy");

   mact_in_busy_a: assert property (st_reg.mact |-> st_reg.busy || $past(stop_det))
      else $error("master active outside a bus transaction");

   tx_thresh_a: assert property ((tx_count <= tx_thresh) |=> st_reg.flags[`ICF_FL_TXTH])
      else $error("transmit threshold flag not set");

   rx_thresh_a: assert property ((rx_count < rx_thresh) |=> !st_reg.flags[`ICF_FL_RXTH])
      else $error("receive threshold flag not cleared");

   done_clear_a: assert property (wr_ok && reg_hit(avs_address, `ICF_OFF_FLAGS) && avs_byteenable[0]
      && avs_writedata[`ICF_FL_DONE] && !ev_done |=> !st_reg.flags[`ICF_FL_DONE])
      else $error("done flag not cleared by write of one");

   irq_gate_a: assert property (|(st_reg.flags & st_reg.enables) |=> irq)
      else $error("interrupt not raised for enabled flag");

   busy_seen_c: cover property ($rose(st_reg.busy));
   irq_seen_c: cover property ($rose(irq));
   write_done_c: cover property (wr_ok);
   master_txn_c: cover property ($rose(st_reg.mact));

endmodule

// file: test/icf_bus_partner.sv
`timescale 1ns/100ps

// External master on the two-wire bus, with pull-ups on both lines.
module icf_bus_partner (
   // Device pin drivers.
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe,
   // Resolved line levels.
   output logic scl_i,
   output logic sda_i
);
   logic scl_low = 1'b0;
   logic sda_low = 1'b0;

   // Open-drain wiring: a released line is pulled high.
   assign scl_i = !(scl_low || (scl_oe && !scl_o));
   assign sda_i = !(sda_low || (sda_oe && !sda_o));

   // Clock runs only inside a frame, 48 ns period; SCL is never held beyond its half period.
   task automatic frame(input int bits);
      sda_low = 1'b1;
      #24 scl_low = 1'b1;
      repeat (bits) begin
         #12 sda_low = $random;
         #12 scl_low = 1'b0;
         #24 scl_low = 1'b1;
      end
      #12 sda_low = 1'b1;
      #12 scl_low = 1'b0;
      #24 sda_low = 1'b0;
   endtask
endmodule

// file: test/tb_icf_control_flags.sv
`timescale 1ns/100ps

module tb_icf_control_flags;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
   logic clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, rw = 1'b0, last_rw = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h00000000, avs_readdata, exp_q[$], e;
   logic avs_waitrequest, scl_i, sda_i, scl_o, scl_oe, sda_o, sda_oe, irq, tx_lock_flush, hw_scl_low = 1'b0;
   logic [7:0] cfg;
   logic [12:0] ev = 13'h0000;
   logic [3:0] tx_count = 4'h0, rx_count = 4'h0, tx_thresh = 4'h0, rx_thresh = 4'h0;
   logic [3:0] fst = 4'h5;
   logic hw_sda_low = 1'b0;
   logic [23:0] x;
   int miscompares = 0, check_count = 0;
   int seed = 32'hE2B834F5;
   localparam logic [15:0] TC [0:16] = '{16'h0005, 16'h0005, 16'h0001, 16'h0005, 16'h0003, 16'h0003,
      16'h0003, 16'h0003, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0009, 16'h0001, 16'h0000, 16'h0001};
   localparam logic [12:0] TP [0:16] = '{13'h0001, 13'h0002, 13'h0002, 13'h0005, 13'h0008, 13'h0010,
      13'h0040, 13'h0080, 13'h0020, 13'h0100, 13'h0400, 13'h0800, 13'h1000, 13'h0200, 13'h0200, 13'h0100, 13'h0008};
   localparam logic [23:0] TX [0:16] = '{24'h000008, 24'h000004, 24'h000000, 24'h001008, 24'h000800,
      24'h000400, 24'h000100, 24'h000080, 24'h000200, 24'h000001, 24'h008000, 24'h002000, 24'h004000,
      24'h000002, 24'h000000, 24'h000000, 24'h000000};

   initial begin
      forever #2.5 clk = ~clk;
   end

   icf_control_flags dut (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
      .sda_o(sda_o), .sda_oe(sda_oe), .hw_scl_low(hw_scl_low), .hw_sda_low(hw_sda_low), .ev_addr_match(ev[0]),
      .ev_gen_call(ev[1]), .ev_rw_bit(rw), .ev_fifo_not_ready(ev[2]), .ev_data_nack(ev[3]),
      .ev_addr_nack(ev[4]), .ev_hold_timeout(ev[5]), .ev_arb_lost(ev[6]), .ev_addr_ack(ev[7]),
      .ev_done(ev[8]), .ev_rx_byte(ev[9]), .ev_tx_lock(ev[10]), .ev_misplaced_start(ev[11]),
      .ev_misplaced_stop(ev[12]), .tx_full(fst[3]), .tx_empty(fst[2]), .rx_full(fst[1]), .rx_empty(fst[0]),
      .tx_count(tx_count), .rx_count(rx_count), .tx_thresh(tx_thresh), .rx_thresh(rx_thresh),
      .periph_enable(cfg[0]), .master_mode(cfg[1]), .general_call_accept(cfg[2]),
      .interactive_receive(cfg[3]), .interactive_nack(cfg[4]), .stretch_disable(cfg[5]),
      .single_master_drive(cfg[6]), .high_speed_enable(cfg[7]), .tx_lock_flush(tx_lock_flush), .irq(irq));

   icf_bus_partner p (.scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl_i),
      .sda_i(sda_i));

   // The driver notes each expected read value; this monitor takes it when the data arrive.
   always @(posedge clk) begin
      if (avs_read && !avs_waitrequest) begin
         e = exp_q.pop_front();
         `CHK(avs_readdata, e)
      end
   end

   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] d);
      exp_q.push_back(d);
      bus(1'b0, a, d);
   endtask

   task automatic print_verdict;
      if (miscompares == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      #250000;
      miscompares++;
      print_verdict();
   end

   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(6'h00, 32'h00000300);
      rd(6'h04, 32'h0000000A);
      rd(6'h08, 32'h00000030);
      rd(6'h0C, 32'h00000000);
      bus(1'b1, 6'h10, 32'hFFFFFFFF);
      rd(6'h10, 32'h00000000);
      bus(1'b1, 6'h00, 32'hFFFFFFFF);
      repeat (4) @(posedge clk);
      rd(6'h00, 32'h0000B7DF);
      `CHK(cfg, 8'hFF)
      bus(1'b1, 6'h00, 32'h00000401);
      repeat (4) @(posedge clk);
      rd(6'h00, 32'h00000401);
      `CHK({scl_oe, sda_oe, scl_o}, 3'b110)
      hw_scl_low <= 1'b1;
      bus(1'b1, 6'h00, 32'h00002001);
      repeat (3) @(posedge clk);
      `CHK({scl_oe, scl_o}, 2'b10)
      hw_scl_low <= 1'b0;
      bus(1'b1, 6'h0C, 32'hFFFFFFFF);
      rd(6'h0C, 32'h00C0FFFF);
      bus(1'b1, 6'h0C, 32'h00C0FFCF);
      // Role and option bits change only between events, with the bus idle.
      for (int i = 0; i < 17; i++) begin
         bus(1'b1, 6'h00, {16'h0000, TC[i]});
         rw <= $random(seed);
         x = TX[i];
         ev <= TP[i];
         @(posedge clk);
         ev <= 13'h0000;
         if (x[3] || x[2]) last_rw = rw;
         if (TP[i][0] && x[3]) x = x | (rw ? 24'h400000 : 24'h800000);
         repeat (3) @(posedge clk);
         `CHK(irq, |x)
         `CHK(tx_lock_flush, x[15])
         rd(6'h08, {8'h00, x | 24'h000030});
         rd(6'h00, {16'h0000, TC[i] | 16'h0300 | {4'h0, last_rw, 11'h000}});
         bus(1'b1, 6'h08, 32'hFFFFFFFF);
         repeat (2) @(posedge clk);
         `CHK({irq, tx_lock_flush}, 2'b00)
      end
      tx_count <= 4'h1;
      rx_thresh <= 4'h2;
      rx_count <= 4'h1;
      bus(1'b1, 6'h08, 32'hFFFFFFFF);
      rd(6'h08, 32'h00000000);
      tx_count <= 4'h0;
      rx_count <= 4'h2;
      bus(1'b1, 6'h0C, 32'h00000030);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b1)
      bus(1'b1, 6'h0C, 32'h00000000);
      bus(1'b1, 6'h00, 32'h00000003);
      fork
         p.frame(9);
         begin
            #150;
            @(posedge clk);
            rd(6'h04, 32'h0000002B);
         end
      join
      repeat (8) @(posedge clk);
      rd(6'h04, 32'h0000000A);
      rd(6'h08, 32'h00000070);
      fst <= 4'hA;
      repeat (2) @(posedge clk);
      rd(6'h04, 32'h00000014);
      hw_sda_low <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK({sda_oe, sda_o}, 2'b10)
      print_verdict();
   end
endmodule
